/* verilog/rcg_top.sv */
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rcg_top (
   input  wire logic                     ref_clk,
   input  wire logic                     rst,
   // AXI4-Lite write address
   input  wire logic [31:0]              s_axi_awaddr,
   input  wire logic [2:0]               s_axi_awprot,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [31:0]              s_axi_araddr,
   input  wire logic [2:0]               s_axi_arprot,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready,
   // Power state and companion gates
   input  wire rcg_pkg::rcg_pwr_t        power_state,
   input  wire logic                     auto_sleep_gating_select,
   input  wire logic [31:0]              sleep_peripheral_clock_gate_1,
   input  wire logic [31:0]              deep_sleep_peripheral_clock_gate_1,
   // Peripheral access monitor
   input  wire rcg_pkg::rcg_periph_req_t periph_req,
   output logic                          periph_fault,
   output logic                          periph_ok,
   // Clock enables and interrupt
   output logic [31:0]                   unit_clk_en,
   output logic                          irq
);
   import rcg_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [31:0] run_peripheral_clock_gate_1_r;
   logic [31:0] irq_stat_r;
   logic [31:0] irq_mask_r;
   logic [31:0] eff_gate_r;
   logic [31:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        aw_got_r;
   logic        w_got_r;
   logic        awready_r;
   logic        wready_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        arready_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        fault_r;
   logic        ok_r;
   logic        irq_r;

   // ---------------------------------------------------------------
   // Write path decode
   // ---------------------------------------------------------------
   wire logic        aw_take;
   wire logic        w_take;
   wire logic        wr_go;
   wire logic        wr_in_base;
   wire logic [11:0] wr_off;
   wire logic        wr_run;
   wire logic        wr_stat;
   wire logic        wr_mask;
   wire logic        wr_eff;
   wire logic        wr_hit;
   wire logic [31:0] run_nxt;
   wire logic [31:0] mask_nxt;
   wire logic [31:0] stat_clr;

   // Channel handshakes
   assign aw_take = s_axi_awvalid && awready_r;
   assign w_take  = s_axi_wvalid && wready_r;
   // Both halves held and no response pending
   assign wr_go   = aw_got_r && w_got_r && !bvalid_r;

   // Address match within the system-control page
   assign wr_in_base = (aw_addr_r[31:12] == RCG_BASE_ADDR[31:12]);
   assign wr_off     = aw_addr_r[11:0];
   assign wr_run  = wr_in_base && (wr_off == RCG_RUN_GATE_OFF);
   assign wr_stat = wr_in_base && (wr_off == RCG_IRQ_STAT_OFF);
   assign wr_mask = wr_in_base && (wr_off == RCG_IRQ_MASK_OFF);
   assign wr_eff  = wr_in_base && (wr_off == RCG_EFF_GATE_OFF);
   assign wr_hit  = wr_run || wr_stat || wr_mask || wr_eff;

   // New gate value; reserved and upper bits stay zero
   assign run_nxt = rcg_merge(run_peripheral_clock_gate_1_r, w_data_r,
                              w_strb_r)
                    & RCG_RUN_GATE_MASK;
   assign mask_nxt = rcg_merge(irq_mask_r, w_data_r, w_strb_r)
                     & RCG_IRQ_MASK_BITS;
   // Write-one-to-clear of status bits
   assign stat_clr = (wr_go && wr_stat) ?
                     rcg_merge(32'h00000000, w_data_r, w_strb_r) :
                     32'h00000000;

   // ---------------------------------------------------------------
   // Read path decode
   // ---------------------------------------------------------------
   wire logic        ar_take;
   wire logic        rd_in_base;
   wire logic [11:0] rd_off;
   wire logic        rd_hit;
   wire logic [31:0] rd_word;

   assign ar_take    = s_axi_arvalid && arready_r;
   assign rd_in_base = (s_axi_araddr[31:12] == RCG_BASE_ADDR[31:12]);
   assign rd_off     = s_axi_araddr[11:0];

   // Read mux; unmapped addresses return zero with an error
   assign rd_word =
      !rd_in_base ? 32'h00000000 :
      (rd_off == RCG_RUN_GATE_OFF) ? run_peripheral_clock_gate_1_r :
      (rd_off == RCG_IRQ_STAT_OFF) ? irq_stat_r :
      (rd_off == RCG_IRQ_MASK_OFF) ? irq_mask_r :
      (rd_off == RCG_EFF_GATE_OFF) ? eff_gate_r :
      32'h00000000;
   assign rd_hit = rd_in_base &&
                   ((rd_off == RCG_RUN_GATE_OFF) ||
                    (rd_off == RCG_IRQ_STAT_OFF) ||
                    (rd_off == RCG_IRQ_MASK_OFF) ||
                    (rd_off == RCG_EFF_GATE_OFF));

   // ---------------------------------------------------------------
   // Gate selection by power state
   // ---------------------------------------------------------------
   wire logic        use_sleep;
   wire logic        use_deep;
   wire logic [31:0] gate_sel;

   // Companion gates only replace run gates under auto gating
   assign use_sleep = auto_sleep_gating_select &&
                      (power_state == RCG_PWR_SLEEP);
   assign use_deep  = auto_sleep_gating_select &&
                      (power_state == RCG_PWR_DEEP);
   assign gate_sel  =
      use_deep  ? (deep_sleep_peripheral_clock_gate_1 & RCG_RUN_GATE_MASK) :
      use_sleep ? (sleep_peripheral_clock_gate_1 & RCG_RUN_GATE_MASK) :
      run_peripheral_clock_gate_1_r;

   // ---------------------------------------------------------------
   // Peripheral access check
   // ---------------------------------------------------------------
   wire logic        chk_fault;
   wire logic        chk_ok;
   wire logic [31:0] stat_set;
   wire logic [31:0] stat_nxt;

   rcg_fault_check u_fault_check (
      .req   (periph_req),
      .gates (eff_gate_r),
      .fault (chk_fault),
      .ok    (chk_ok)
   );

   // Fault events into the status word; a set beats a clear
   assign stat_set = {30'h0,
                      chk_fault && periph_req.write,
                      chk_fault && !periph_req.write};
   assign stat_nxt = ((irq_stat_r & ~stat_clr) | stat_set)
                     & RCG_IRQ_MASK_BITS;

   // ---------------------------------------------------------------
   // Write channel capture
   // ---------------------------------------------------------------
   // Address half, taken on its own
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aw_got_r  <= 1'b0;
         aw_addr_r <= 32'h00000000;
         awready_r <= 1'b1;
      end else if (aw_take) begin
         aw_got_r  <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
         awready_r <= 1'b0;
      end else if (wr_go) begin
         aw_got_r  <= 1'b0;
         awready_r <= 1'b1;
      end
   end

   // Data half, taken on its own
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         w_got_r  <= 1'b0;
         w_data_r <= 32'h00000000;
         w_strb_r <= 4'h0;
         wready_r <= 1'b1;
      end else if (w_take) begin
         w_got_r  <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
         wready_r <= 1'b0;
      end else if (wr_go) begin
         w_got_r  <= 1'b0;
         wready_r <= 1'b1;
      end
   end

   // Write response
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bvalid_r <= 1'b0;
         bresp_r  <= RCG_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r  <= wr_hit ? RCG_RESP_OKAY : RCG_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   // Run-mode gate word, cleared by reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_peripheral_clock_gate_1_r <= RCG_RUN_GATE_RESET;
      end else if (wr_go && wr_run) begin
         run_peripheral_clock_gate_1_r <= run_nxt;
      end
   end

   // Interrupt mask
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_mask_r <= RCG_IRQ_RESET;
      end else if (wr_go && wr_mask) begin
         irq_mask_r <= mask_nxt;
      end
   end

   // Sticky fault status and the interrupt line
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= RCG_IRQ_RESET;
         irq_r      <= 1'b0;
      end else begin
         irq_stat_r <= stat_nxt;
         irq_r      <= |(stat_nxt & irq_mask_r);
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h00000000;
         rresp_r   <= RCG_RESP_OKAY;
      end else if (ar_take) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_word;
         rresp_r   <= rd_hit ? RCG_RESP_OKAY : RCG_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Applied gates and access outcome
   // ---------------------------------------------------------------
   // Gate word that the units see this cycle
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         eff_gate_r <= RCG_RUN_GATE_RESET;
      end else begin
         eff_gate_r <= gate_sel;
      end
   end

   // One-cycle outcome pulses for the bus fabric
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fault_r <= 1'b0;
         ok_r    <= 1'b0;
      end else begin
         fault_r <= chk_fault;
         ok_r    <= chk_ok;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;
   assign unit_clk_en   = eff_gate_r;
   assign periph_fault  = fault_r;
   assign periph_ok     = ok_r;
   assign irq           = irq_r;

endmodule
`default_nettype wire

/* verilog/rcg_pkg.sv */
//
// Functional notes
// - Each implemented bit enables the clock of one peripheral unit.
// - Access to a unit whose gate is zero ends in a bus fault.
// - Reset clears the whole gate register so every unit is off.
// - Register decoded at offset 0x104 from base 0x400FE000, 32-bit.
// - Run register gates apply while running; companions serve sleep.
// - Sleep and deep-sleep gates apply only when auto gating is set.
// - Bits 19 to 16 gate timers 3 to 0, read/write, reset zero.
// - Bits 14 and 12 gate two-wire modules 1 and 0.
// - Bits 5 and 4 gate synchronous serial modules 1 and 0.
// - Bits 2, 1 and 0 gate asynchronous serial ports 2, 1, 0.
// - Bits 15, 13, 11:6 and 3 read zero and ignore writes.
`default_nettype none
package rcg_pkg;

   // ---------------------------------------------------------------
   // Address map
   // ---------------------------------------------------------------
   localparam logic [31:0] RCG_BASE_ADDR = 32'h400fe000;
   localparam logic [11:0] RCG_RUN_GATE_OFF = 12'h104;
   localparam logic [11:0] RCG_IRQ_STAT_OFF = 12'h1f0;
   localparam logic [11:0] RCG_IRQ_MASK_OFF = 12'h1f4;
   localparam logic [11:0] RCG_EFF_GATE_OFF = 12'h1f8;

   // ---------------------------------------------------------------
   // Gate register layout
   // ---------------------------------------------------------------
   localparam int RCG_ASYNC_ZERO_BIT = 0;
   localparam int RCG_ASYNC_1_BIT    = 1;
   localparam int RCG_ASYNC_2_BIT    = 2;
   localparam int RCG_SYNC_ZERO_BIT  = 4;
   localparam int RCG_SYNC_1_BIT     = 5;
   localparam int RCG_TWO_ZERO_BIT   = 12;
   localparam int RCG_TWO_1_BIT      = 14;
   localparam int RCG_TIMER_ZERO_BIT = 16;
   localparam logic [31:0] RCG_RUN_GATE_MASK  = 32'h000f5037;
   localparam logic [31:0] RCG_RUN_GATE_RESET = 32'h00000000;

   // ---------------------------------------------------------------
   // Interrupt status layout
   // ---------------------------------------------------------------
   localparam int RCG_IRQ_RD_FAULT_BIT = 0;
   localparam int RCG_IRQ_WR_FAULT_BIT = 1;
   localparam logic [31:0] RCG_IRQ_MASK_BITS = 32'h00000003;
   localparam logic [31:0] RCG_IRQ_RESET     = 32'h00000000;

   // ---------------------------------------------------------------
   // AXI responses and unit count
   // ---------------------------------------------------------------
   localparam logic [1:0] RCG_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RCG_RESP_SLVERR = 2'h2;
   localparam logic [3:0] RCG_UNIT_COUNT  = 4'hb;

   // Power state of the processor
   typedef enum logic [1:0] {
      RCG_PWR_RUN,
      RCG_PWR_SLEEP,
      RCG_PWR_DEEP
   } rcg_pwr_t;

   // One access aimed at a gated peripheral
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [3:0] unit;
   } rcg_periph_req_t;

   // Gate bit position of a unit index; 32 means no such unit
   function automatic logic [5:0] rcg_unit_bit(input logic [3:0] unit);
      logic [5:0] pos;
      pos = 6'h20;
      case (unit)
         4'h0: pos = 6'(RCG_ASYNC_ZERO_BIT);
         4'h1: pos = 6'(RCG_ASYNC_1_BIT);
         4'h2: pos = 6'(RCG_ASYNC_2_BIT);
         4'h3: pos = 6'(RCG_SYNC_ZERO_BIT);
         4'h4: pos = 6'(RCG_SYNC_1_BIT);
         4'h5: pos = 6'(RCG_TWO_ZERO_BIT);
         4'h6: pos = 6'(RCG_TWO_1_BIT);
         4'h7: pos = 6'(RCG_TIMER_ZERO_BIT);
         4'h8: pos = 6'(RCG_TIMER_ZERO_BIT + 1);
         4'h9: pos = 6'(RCG_TIMER_ZERO_BIT + 2);
         4'ha: pos = 6'(RCG_TIMER_ZERO_BIT + 3);
         default: pos = 6'h20;
      endcase
      return pos;
   endfunction

   // Merge write data into a word under byte strobes
   function automatic logic [31:0] rcg_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (data & m);
   endfunction

endpackage
`default_nettype wire

/* verilog/rcg_fault_check.sv */
`timescale 1ns/1ps
`default_nettype none
module rcg_fault_check (
   input  wire rcg_pkg::rcg_periph_req_t req,
   input  wire logic [31:0]              gates,
   output logic                          fault,
   output logic                          ok
);
   import rcg_pkg::*;

   // ---------------------------------------------------------------
   // Gate lookup
   // ---------------------------------------------------------------
   wire logic [5:0] pos;
   wire logic       known;
   wire logic       gate_on;

   // Units outside the table count as unclocked
   assign pos     = rcg_unit_bit(req.unit);
   assign known   = (req.unit < RCG_UNIT_COUNT);
   assign gate_on = known && gates[pos[4:0]];

   // Classify the access
   assign fault = req.valid && !gate_on;
   assign ok    = req.valid && gate_on;

endmodule
`default_nettype wire

/* bench/rcg_top_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module rcg_top_checker (
   input wire logic                     ref_clk,
   input wire logic                     rst,
   input wire logic                     s_axi_awvalid,
   input wire logic                     s_axi_awready,
   input wire logic                     s_axi_wvalid,
   input wire logic                     s_axi_wready,
   input wire logic                     s_axi_bvalid,
   input wire logic                     s_axi_arvalid,
   input wire logic                     s_axi_arready,
   input wire logic [31:0]              s_axi_rdata,
   input wire logic                     s_axi_rvalid,
   input wire logic                     s_axi_rready,
   input wire rcg_pkg::rcg_periph_req_t periph_req,
   input wire logic                     periph_fault,
   input wire logic                     periph_ok,
   input wire logic [31:0]              unit_clk_en,
   input wire logic                     irq
);
   import rcg_pkg::*;

   // ----------------------------------------------------------
   // Gate and bus properties
   // ----------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_mask;
      (unit_clk_en & ~RCG_RUN_GATE_MASK) == 32'h0;
   endproperty
   a_mask: assert property (p_mask)
      else $error("reserved enable set");
   property p_gated;
      periph_req.valid && unit_clk_en == 32'h0 |=> periph_fault && !periph_ok;
   endproperty
   a_gated: assert property (p_gated)
      else $error("no fault on gated unit");
   property p_open;
      periph_req.valid && periph_req.unit < 4'hb &&
      unit_clk_en == RCG_RUN_GATE_MASK |=> periph_ok && !periph_fault;
   endproperty
   a_open: assert property (p_open)
      else $error("clocked unit refused");
   property p_pulse;
      periph_fault |-> $past(periph_req.valid);
   endproperty
   a_pulse: assert property (p_pulse)
      else $error("fault without access");
   property p_rst;
      $fell(rst) |-> unit_clk_en == 32'h0 && !irq && !periph_ok;
   endproperty
   a_rst: assert property (p_rst)
      else $error("state not cleared");
   property p_wr_lat;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
      !s_axi_bvalid |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat)
      else $error("late write answer");
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd_lat: assert property (p_rd_lat)
      else $error("late read answer");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
endmodule

bind rcg_top rcg_top_checker rcg_top_checker_inst (
   .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .periph_req(periph_req),
   .periph_fault(periph_fault), .periph_ok(periph_ok),
   .unit_clk_en(unit_clk_en), .irq(irq));
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rcg_pkg::*;

   // ----------------------------------------------------------
   // Stimulus and observed signals
   // ----------------------------------------------------------
   localparam logic [31:0] RUN_A = 32'h400fe104;
   localparam logic [31:0] BAD_A = 32'h400fe108;
   localparam logic [31:0] STAT_A = 32'h400fe1f0;
   localparam logic [31:0] MASK_A = 32'h400fe1f4;
   localparam logic [31:0] EFF_A = 32'h400fe1f8;
   localparam int UBIT [11] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19};
   logic ref_clk = 1'b0, rst = 1'b1;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic [31:0] ss_gate = 32'h0, ds_gate = 32'h0, rdata, en;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, auto_sel = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, fault, ok, irq;
   logic [1:0] bresp, rresp;
   rcg_pwr_t pstate = RCG_PWR_RUN;
   rcg_periph_req_t preq = '0;
   int errors = 0, total_checks = 0;

   always #2.5 ref_clk = ~ref_clk;

   rcg_top rcg_top_inst (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .power_state(pstate),
      .auto_sleep_gating_select(auto_sel),
      .sleep_peripheral_clock_gate_1(ss_gate),
      .deep_sleep_peripheral_clock_gate_1(ds_gate), .periph_req(preq),
      .periph_fault(fault), .periph_ok(ok), .unit_clk_en(en), .irq(irq));

   // ----------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Write one word, hold each channel until taken, compare response
   task automatic wr(input logic [31:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [1:0] exp_r);
      int n;
      n = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      bready <= 1'b0;
      if (n >= 40) errors++;
      chk(bresp, exp_r);
   endtask

   // Read one word; ready raised late so the slave must hold data
   task automatic rd(input logic [31:0] a, input logic [31:0] exp_d,
                     input logic [1:0] exp_r);
      int n;
      n = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      rready <= 1'b1;
      @(posedge ref_clk);
      rready <= 1'b0;
      if (n >= 40) errors++;
      chk(rdata, exp_d);
      chk(rresp, exp_r);
   endtask

   // One peripheral access, answer pulse sampled one cycle later
   task automatic acc(input logic [3:0] u, input logic w, input logic f);
      @(posedge ref_clk);
      preq <= {1'b1, w, u};
      @(posedge ref_clk);
      preq <= '0;
      @(posedge ref_clk);
      chk(fault, f);
      chk(ok, !f);
   endtask

   task automatic settle;
      repeat (2) @(posedge ref_clk);
   endtask

   // ----------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------
   task automatic t_reset;
      chk(en, 32'h0);
      rd(RUN_A, 32'h0, RCG_RESP_OKAY);
      acc(4'h0, 1'b0, 1'b1);
      $display("test reset done");
   endtask

   task automatic t_bits;
      logic [31:0] g;
      for (int i = 0; i < 11; i++) begin
         g = 32'h1 << UBIT[i];
         wr(RUN_A, g, 4'hf, RCG_RESP_OKAY);
         rd(RUN_A, g, RCG_RESP_OKAY);
         settle();
         chk(en, g);
         acc(4'(i), i[0], 1'b0);
         acc(4'((i + 1) % 11), 1'b1, 1'b1);
      end
      acc(4'hf, 1'b0, 1'b1);
      $display("test bits done");
   endtask

   task automatic t_resv;
      wr(RUN_A, 32'hffffffff, 4'hf, RCG_RESP_OKAY);
      rd(RUN_A, 32'h000f5037, RCG_RESP_OKAY);
      wr(RUN_A, 32'h0, 4'hf, RCG_RESP_OKAY);
      wr(RUN_A, 32'hffffffff, 4'h1, RCG_RESP_OKAY);
      rd(RUN_A, 32'h00000037, RCG_RESP_OKAY);
      wr(RUN_A, 32'h00000037, 4'hf, RCG_RESP_OKAY);
      wr(BAD_A, 32'hffffffff, 4'hf, RCG_RESP_SLVERR);
      rd(BAD_A, 32'h0, RCG_RESP_SLVERR);
      rd(EFF_A, 32'h00000037, RCG_RESP_OKAY);
      $display("test reserved done");
   endtask

   task automatic t_irq;
      // Clear faults left by earlier tests
      wr(STAT_A, 32'h3, 4'hf, RCG_RESP_OKAY);
      rd(STAT_A, 32'h0, RCG_RESP_OKAY);
      acc(4'h7, 1'b0, 1'b1);
      chk(irq, 1'b0);
      rd(STAT_A, 32'h1, RCG_RESP_OKAY);
      wr(MASK_A, 32'h3, 4'hf, RCG_RESP_OKAY);
      settle();
      chk(irq, 1'b1);
      acc(4'ha, 1'b1, 1'b1);
      rd(STAT_A, 32'h3, RCG_RESP_OKAY);
      wr(STAT_A, 32'h1, 4'hf, RCG_RESP_OKAY);
      rd(STAT_A, 32'h2, RCG_RESP_OKAY);
      wr(MASK_A, 32'h1, 4'hf, RCG_RESP_OKAY);
      settle();
      chk(irq, 1'b0);
      wr(STAT_A, 32'h2, 4'hf, RCG_RESP_OKAY);
      rd(STAT_A, 32'h0, RCG_RESP_OKAY);
      $display("test interrupt done");
   endtask

   task automatic t_modes;
      @(posedge ref_clk);
      auto_sel <= 1'b1;
      pstate <= RCG_PWR_SLEEP;
      ss_gate <= 32'hffffffff;
      ds_gate <= 32'h00010000;
      settle();
      chk(en, 32'h000f5037);
      acc(4'ha, 1'b0, 1'b0);
      pstate <= RCG_PWR_DEEP;
      settle();
      chk(en, 32'h00010000);
      acc(4'h7, 1'b1, 1'b0);
      acc(4'h0, 1'b1, 1'b1);
      auto_sel <= 1'b0;
      settle();
      chk(en, 32'h00000037);
      auto_sel <= 1'b1;
      pstate <= RCG_PWR_RUN;
      settle();
      chk(en, 32'h00000037);
      $display("test modes done");
   endtask

   // Reset in mid-run clears a written gate word
   task automatic t_rerst;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      chk(en, 32'h0);
      rd(RUN_A, 32'h0, RCG_RESP_OKAY);
      $display("test reset again done");
   endtask

   // ----------------------------------------------------------
   // Run control
   // ----------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Cuts a hang short
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      wrap_up();
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_bits();
      t_resv();
      t_irq();
      t_modes();
      t_rerst();
      wrap_up();
   end
endmodule
`default_nettype wire
